// [hdl/tuc_channel_clk.sv]
// Per-channel operation clock select, input edge detector and count clock
`timescale 1ns/1ps
module tuc_channel_clk import tuc_pkg::*; (
  input logic pclk,
  input logic presetn,
  input logic unit_on,
  input logic shared_clock_a,
  input logic shared_clock_b,
  input logic [15:0] channel_mode,
  input logic timer_input_pin,
  output logic channel_op_clock,
  output logic channel_count_clock
);
  tuc_chan_state_s r;
  tuc_chan_state_s n;
  logic opsel;
  logic rise;
  logic fall;
  logic valid;
  logic [1:0] esel;

  assign opsel = channel_mode[TUC_MODE_OPCLK_BIT] ? shared_clock_b : shared_clock_a;
  assign rise = timer_input_pin & ~r.pin_q;
  assign fall = ~timer_input_pin & r.pin_q;
  assign esel = channel_mode[TUC_MODE_EDGE_LSB +: 2];
  assign valid = (esel == TUC_EDGE_FALL) ? fall : (esel == TUC_EDGE_RISE) ? rise : (rise | fall);

  always_comb begin
    n = r;
    n.op_clk = opsel;
    // Edge detector samples only on operation clock pulses
    if (opsel) n.pin_q = timer_input_pin;
    n.cnt_clk = channel_mode[TUC_MODE_CNTCLK_BIT] ? (opsel & valid) : opsel;
    if (!unit_on) n = '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) r <= '0;
    else r <= n;
  end

  assign channel_op_clock = r.op_clk;
  assign channel_count_clock = r.cnt_clk;

  property p_opclk_b;
    @(posedge pclk) disable iff (!presetn)
      (unit_on && channel_mode[TUC_MODE_OPCLK_BIT] && shared_clock_b) |=> channel_op_clock;
  endproperty
  a_opclk_b: assert property (p_opclk_b) else $error("second shared clock not selected");
  property p_cnt_is_op;
    @(posedge pclk) disable iff (!presetn)
      (unit_on && !channel_mode[TUC_MODE_CNTCLK_BIT]) |=> (channel_count_clock == channel_op_clock);
  endproperty
  a_cnt_is_op: assert property (p_cnt_is_op) else $error("count clock differs from op clock");
  property p_cnt_rise;
    @(posedge pclk) disable iff (!presetn)
      (unit_on && channel_mode[TUC_MODE_CNTCLK_BIT] && opsel && esel == TUC_EDGE_RISE && rise) |=> channel_count_clock;
  endproperty
  a_cnt_rise: assert property (p_cnt_rise) else $error("rising input edge not counted");
  property p_hold_sample;
    @(posedge pclk) disable iff (!presetn) (unit_on && !opsel) |=> $stable(r.pin_q);
  endproperty
  a_hold_sample: assert property (p_hold_sample) else $error("input sampled off the op clock");
endmodule : tuc_channel_clk

// [hdl/tuc_clock_ctrl.sv]
// APB register file and clock control of the two timer units
`timescale 1ns/1ps
// What this block does
// - Unit 0 gets its clock only while its enable bit is one.
// - Unit 1 gets its clock only while its enable bit is one.
// - A disabled unit has its clock stopped and is held in reset.
// - A disabled unit ignores control writes and reads back reset values.
// - Enable register resets to zero; byte and bit writes allowed.
// - Prescaler makes two shared clocks: bits 7..4 second, 3..0 first.
// - Field value k gives the system clock divided by two to k.
// - Mode register holds clock, role, trigger, edge and mode fields.
// - Mode bit 15 picks the first or second shared clock.
// - Selected operation clock drives the channel edge detector.
// - Mode bit 12 low counts on the operation clock.
// - Mode bit 12 high counts on valid input pin edges.
module tuc_clock_ctrl import tuc_pkg::*; #(
  parameter int unsigned NUM_CH0 = TUC_MAX_CH0,
  parameter int unsigned NUM_CH1 = TUC_MAX_CH1
) (
  input logic pclk,
  input logic presetn,
  input tuc_apb_req_s apb_req,
  output tuc_apb_rsp_s apb_rsp,
  input logic [TUC_MAX_CH-1:0] timer_input_pin,
  output logic [1:0] unit_clock_on,
  output logic [1:0] unit_rst_n,
  output logic [TUC_MAX_CH-1:0][15:0] channel_mode,
  output logic [TUC_MAX_CH-1:0] channel_op_clock,
  output logic [TUC_MAX_CH-1:0] channel_count_clock
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (NUM_CH0 < 1 || NUM_CH0 > TUC_MAX_CH0 || NUM_CH1 < 1 || NUM_CH1 > TUC_MAX_CH1) begin : g_bad_param
    $error("unsupported channel count");
  end

  // ****************************************
  // State and helpers
  // ****************************************
  tuc_ctrl_state_s r;
  tuc_ctrl_state_s n;
  tuc_sel_s acc_sel;
  logic setup;
  logic acc_fire;
  logic [1:0] clk_a;
  logic [1:0] clk_b;

  function automatic tuc_sel_s decode(input logic [21:0] addr);
    tuc_sel_s s;
    logic [19:0] idx;
    s.kind = TUC_SEL_NONE;
    s.ch = 4'h0;
    idx = addr[21:2];
    if (addr[1:0] == 2'h0) begin
      if (idx == TUC_IDX_PCE) begin
        s.kind = TUC_SEL_PCE;
      end else if (idx == TUC_IDX_PRESCALER_SELECT_UNIT0) begin
        s.kind = TUC_SEL_PRESCALER_SELECT_UNIT0;
      end else if (idx == TUC_IDX_PRESCALER_SELECT_UNIT1) begin
        s.kind = TUC_SEL_PRESCALER_SELECT_UNIT1;
      end
      for (int i = 0; i < TUC_MAX_CH0; i++) begin
        if (i < NUM_CH0 && idx == TUC_IDX_MODE0 + 20'(i) * TUC_IDX_STEP) begin
          s.kind = TUC_SEL_MODE;
          s.ch = 4'(i);
        end
      end
      for (int i = 0; i < TUC_MAX_CH1; i++) begin
        if (i < NUM_CH1 && idx == TUC_IDX_MODE1 + 20'(i) * TUC_IDX_STEP) begin
          s.kind = TUC_SEL_MODE;
          s.ch = 4'(TUC_UNIT1_BASE + i);
        end
      end
    end
    return s;
  endfunction : decode

  // Byte lanes merge; masked bits always store zero
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] strb, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (strb[0]) v[7:0] = wd[7:0];
    if (strb[1]) v[15:8] = wd[15:8];
    return v & mask;
  endfunction : merge

  assign acc_sel = decode(apb_req.paddr);
  assign setup = apb_req.psel && !apb_req.penable;
  assign acc_fire = (r.st == TUC_ST_ANSWER) && apb_req.psel && apb_req.penable && apb_req.pwrite;

  // ****************************************
  // Register file and APB answer
  // ****************************************
  // Answer is registered so pready and prdata come straight from flops
  always_comb begin
    n = r;
    case (r.st)
      TUC_ST_IDLE: begin
        if (setup) begin
          n.st = TUC_ST_ANSWER;
          n.rsp.pready = 1'b1;
          n.rsp.pslverr = (acc_sel.kind == TUC_SEL_NONE);
          // Disabled units already sit at reset values, so reads show them
          case (acc_sel.kind)
            TUC_SEL_PCE: n.rsp.prdata = {24'h000000, r.pce};
            TUC_SEL_PRESCALER_SELECT_UNIT0: n.rsp.prdata = {16'h0000, r.tps[0]};
            TUC_SEL_PRESCALER_SELECT_UNIT1: n.rsp.prdata = {16'h0000, r.tps[1]};
            TUC_SEL_MODE: n.rsp.prdata = {16'h0000, r.mode[acc_sel.ch]};
            default: n.rsp.prdata = 32'h00000000;
          endcase
        end
      end
      TUC_ST_ANSWER: begin
        n.st = TUC_ST_IDLE;
        n.rsp = '0;
        if (acc_fire) begin
          case (acc_sel.kind)
            TUC_SEL_PCE: begin
              n.pce = 8'(merge({8'h00, r.pce}, apb_req.pwdata[15:0], apb_req.pstrb[1:0],
                               {8'h00, TUC_PCE_MASK}));
            end
            TUC_SEL_PRESCALER_SELECT_UNIT0: begin
              if (r.pce[TUC_PCE_U0_BIT]) begin
                n.tps[0] = merge(r.tps[0], apb_req.pwdata[15:0], apb_req.pstrb[1:0], TUC_TPS_MASK);
              end
            end
            TUC_SEL_PRESCALER_SELECT_UNIT1: begin
              if (r.pce[TUC_PCE_U1_BIT]) begin
                n.tps[1] = merge(r.tps[1], apb_req.pwdata[15:0], apb_req.pstrb[1:0], TUC_TPS_MASK);
              end
            end
            TUC_SEL_MODE: begin
              // Written even while counting; keeping to the stop rule is software's job
              if (r.pce[TUC_PCE_U0_BIT + (acc_sel.ch >= TUC_UNIT1_BASE)]) begin
                n.mode[acc_sel.ch] = merge(r.mode[acc_sel.ch], apb_req.pwdata[15:0],
                                           apb_req.pstrb[1:0], TUC_MODE_MASK);
              end
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        n.st = TUC_ST_IDLE;
        n.rsp = '0;
      end
    endcase
    // Clearing an enable bit resets that unit's registers the same edge
    for (int u = 0; u < 2; u++) begin
      if (!n.pce[TUC_PCE_U0_BIT + u]) n.tps[u] = TUC_TPS_RST;
    end
    for (int c = 0; c < TUC_MAX_CH; c++) begin
      if (!n.pce[TUC_PCE_U0_BIT + (c >= TUC_UNIT1_BASE)]) n.mode[c] = TUC_MODE_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= TUC_CTRL_RST;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign apb_rsp = r.rsp;
  assign unit_clock_on = {r.pce[TUC_PCE_U1_BIT], r.pce[TUC_PCE_U0_BIT]};
  assign unit_rst_n = {r.pce[TUC_PCE_U1_BIT], r.pce[TUC_PCE_U0_BIT]};
  assign channel_mode = r.mode;

  // ****************************************
  // Prescalers and channels
  // ****************************************
  for (genvar u = 0; u < 2; u++) begin : g_unit
    tuc_prescaler u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .unit_on(r.pce[TUC_PCE_U0_BIT + u]),
      .prescale_a_field(r.tps[u][TUC_TPS_A_LSB +: TUC_PRS_W]),
      .prescale_b_field(r.tps[u][TUC_TPS_B_LSB +: TUC_PRS_W]),
      .shared_clock_a(clk_a[u]),
      .shared_clock_b(clk_b[u])
    );
  end

  for (genvar c = 0; c < TUC_MAX_CH; c++) begin : g_chan
    localparam int unsigned U = (c >= TUC_UNIT1_BASE) ? 1 : 0;
    localparam bit LIVE = (U == 0) ? (c < NUM_CH0) : (c - TUC_UNIT1_BASE < NUM_CH1);
    if (LIVE) begin : g_live
      tuc_channel_clk u_ch (
        .pclk(pclk),
        .presetn(presetn),
        .unit_on(r.pce[TUC_PCE_U0_BIT + U]),
        .shared_clock_a(clk_a[U]),
        .shared_clock_b(clk_b[U]),
        .channel_mode(r.mode[c]),
        .timer_input_pin(timer_input_pin[c]),
        .channel_op_clock(channel_op_clock[c]),
        .channel_count_clock(channel_count_clock[c])
      );
    end else begin : g_absent
      assign channel_op_clock[c] = 1'b0;
      assign channel_count_clock[c] = 1'b0;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_pce_write;
    @(posedge pclk) disable iff (!presetn)
      (acc_fire && acc_sel.kind == TUC_SEL_PCE && apb_req.pstrb[0])
      |=> (unit_clock_on == ($past(apb_req.pwdata[1:0])));
  endproperty
  a_pce_write: assert property (p_pce_write) else $error("enable write not applied");

  property p_u0_off_quiet;
    @(posedge pclk) disable iff (!presetn)
      !unit_clock_on[0] [*2] |-> (clk_a[0] == 1'b0 && clk_b[0] == 1'b0);
  endproperty
  a_u0_off_quiet: assert property (p_u0_off_quiet) else $error("unit 0 clocked while off");

  property p_u1_off_quiet;
    @(posedge pclk) disable iff (!presetn)
      !unit_clock_on[1] [*3] |-> (channel_op_clock[TUC_UNIT1_BASE] == 1'b0);
  endproperty
  a_u1_off_quiet: assert property (p_u1_off_quiet) else $error("unit 1 channel clocked while off");

  property p_off_reset;
    @(posedge pclk) disable iff (!presetn)
      !unit_rst_n[0] |-> (r.tps[0] == TUC_TPS_RST && channel_mode[0] == TUC_MODE_RST);
  endproperty
  a_off_reset: assert property (p_off_reset) else $error("unit 0 not held in reset");

  property p_off_read;
    @(posedge pclk) disable iff (!presetn)
      (setup && !apb_req.pwrite && acc_sel.kind == TUC_SEL_PRESCALER_SELECT_UNIT0 && !unit_clock_on[0] && r.st == TUC_ST_IDLE)
      |=> (apb_rsp.pready && apb_rsp.prdata == 32'h00000000);
  endproperty
  a_off_read: assert property (p_off_read) else $error("disabled unit read not reset value");

  property p_mode_write;
    @(posedge pclk) disable iff (!presetn)
      (acc_fire && acc_sel.kind == TUC_SEL_MODE && acc_sel.ch == 4'h0 && unit_clock_on[0]
       && apb_req.pstrb[1:0] == 2'h3)
      |=> (channel_mode[0] == ($past(apb_req.pwdata[15:0]) & TUC_MODE_MASK));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode register not stored");

  property p_answer_once;
    @(posedge pclk) disable iff (!presetn) apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  a_answer_once: assert property (p_answer_once) else $error("pready held past one cycle");

  c_pce_write: cover property (@(posedge pclk) disable iff (!presetn) acc_fire && acc_sel.kind == TUC_SEL_PCE);
  c_mode_read: cover property (@(posedge pclk) disable iff (!presetn)
    setup && !apb_req.pwrite && acc_sel.kind == TUC_SEL_MODE);
  c_count_pin: cover property (@(posedge pclk) disable iff (!presetn)
    channel_count_clock[0] && channel_mode[0][TUC_MODE_CNTCLK_BIT]);
  c_slverr: cover property (@(posedge pclk) disable iff (!presetn) apb_rsp.pslverr);

endmodule : tuc_clock_ctrl

// [hdl/tuc_prescaler.sv]
// Free-running divider making the two shared operation clock pulses of one unit
`timescale 1ns/1ps
module tuc_prescaler import tuc_pkg::*; (
  input logic pclk,
  input logic presetn,
  input logic unit_on,
  input logic [TUC_PRS_W-1:0] prescale_a_field,
  input logic [TUC_PRS_W-1:0] prescale_b_field,
  output logic shared_clock_a,
  output logic shared_clock_b
);
  tuc_pre_state_s r;
  tuc_pre_state_s n;

  function automatic logic tick(input logic [TUC_DIV_W-1:0] cnt, input logic [TUC_PRS_W-1:0] k);
    logic [TUC_DIV_W-1:0] m;
    m = TUC_DIV_W'((16'h0001 << k) - 16'h0001);
    return (cnt & m) == m;
  endfunction : tick

  // Enable pulses, not derived clocks: everything stays on pclk
  always_comb begin
    n = r;
    if (unit_on) begin
      n.cnt = r.cnt + 15'h0001;
      n.pulse_a = tick(r.cnt, prescale_a_field);
      n.pulse_b = tick(r.cnt, prescale_b_field);
    end else begin
      n = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) r <= '0;
    else r <= n;
  end

  assign shared_clock_a = r.pulse_a;
  assign shared_clock_b = r.pulse_b;

  property p_div1_a;
    @(posedge pclk) disable iff (!presetn) (unit_on && prescale_a_field == 4'h0) |=> shared_clock_a;
  endproperty
  a_div1_a: assert property (p_div1_a) else $error("k=0 must pulse every cycle");
  property p_div1_b;
    @(posedge pclk) disable iff (!presetn) (unit_on && prescale_b_field == 4'h0) |=> shared_clock_b;
  endproperty
  a_div1_b: assert property (p_div1_b) else $error("second clock field not applied");
  property p_div2_single;
    @(posedge pclk) disable iff (!presetn)
      (unit_on && prescale_a_field == 4'h1 && $stable(prescale_a_field) && shared_clock_a) |=> !shared_clock_a;
  endproperty
  a_div2_single: assert property (p_div2_single) else $error("pulse longer than one cycle");
endmodule : tuc_prescaler

// [pkg/tuc_pkg.sv]
// Shared constants and types for the timer unit clock control block
package tuc_pkg;
  // ****************************************
  // Register indices (byte address is four times the index)
  // ****************************************
  localparam logic [19:0] TUC_IDX_PCE = 20'hf00f0;
  localparam logic [19:0] TUC_IDX_MODE0 = 20'hf0190;
  localparam logic [19:0] TUC_IDX_PRESCALER_SELECT_UNIT0 = 20'hf01b6;
  localparam logic [19:0] TUC_IDX_MODE1 = 20'hf01c8;
  localparam logic [19:0] TUC_IDX_PRESCALER_SELECT_UNIT1 = 20'hf01de;
  localparam logic [19:0] TUC_IDX_STEP = 20'h00002;
  // ****************************************
  // Channel counts
  // ****************************************
  localparam int unsigned TUC_MAX_CH0 = 8;
  localparam int unsigned TUC_MAX_CH1 = 4;
  localparam int unsigned TUC_MAX_CH = 12;
  localparam int unsigned TUC_UNIT1_BASE = 8;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int unsigned TUC_PCE_U0_BIT = 0;
  localparam int unsigned TUC_PCE_U1_BIT = 1;
  localparam logic [7:0] TUC_PCE_MASK = 8'h3f;
  localparam logic [7:0] TUC_PCE_RST = 8'h00;
  localparam int unsigned TUC_PRS_W = 4;
  localparam int unsigned TUC_TPS_A_LSB = 0;
  localparam int unsigned TUC_TPS_B_LSB = 4;
  localparam logic [15:0] TUC_TPS_MASK = 16'h00ff;
  localparam logic [15:0] TUC_TPS_RST = 16'h0000;
  localparam int unsigned TUC_MODE_OPCLK_BIT = 15;
  localparam int unsigned TUC_MODE_CNTCLK_BIT = 12;
  localparam int unsigned TUC_MODE_EDGE_LSB = 6;
  localparam logic [15:0] TUC_MODE_MASK = 16'h9fcf;
  localparam logic [15:0] TUC_MODE_RST = 16'h0000;
  localparam logic [1:0] TUC_EDGE_FALL = 2'h0;
  localparam logic [1:0] TUC_EDGE_RISE = 2'h1;
  localparam int unsigned TUC_DIV_W = 15;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic {TUC_ST_IDLE, TUC_ST_ANSWER} tuc_ap_e;
  typedef enum logic [2:0] {TUC_SEL_NONE, TUC_SEL_PCE, TUC_SEL_PRESCALER_SELECT_UNIT0, TUC_SEL_PRESCALER_SELECT_UNIT1, TUC_SEL_MODE} tuc_sel_e;
  typedef struct packed {tuc_sel_e kind; logic [3:0] ch;} tuc_sel_s;
  typedef struct packed {
    logic psel; logic penable; logic pwrite; logic [21:0] paddr; logic [31:0] pwdata; logic [3:0] pstrb;
  } tuc_apb_req_s;
  typedef struct packed {logic pready; logic [31:0] prdata; logic pslverr;} tuc_apb_rsp_s;
  typedef struct packed {
    tuc_ap_e st; tuc_apb_rsp_s rsp; logic [7:0] pce; logic [1:0][15:0] tps; logic [TUC_MAX_CH-1:0][15:0] mode;
  } tuc_ctrl_state_s;
  localparam tuc_ctrl_state_s TUC_CTRL_RST = '{st: TUC_ST_IDLE, rsp: '0, pce: TUC_PCE_RST,
    tps: {2{TUC_TPS_RST}}, mode: {TUC_MAX_CH{TUC_MODE_RST}}};
  typedef struct packed {logic [TUC_DIV_W-1:0] cnt; logic pulse_a; logic pulse_b;} tuc_pre_state_s;
  typedef struct packed {logic pin_q; logic op_clk; logic cnt_clk;} tuc_chan_state_s;
endpackage : tuc_pkg

// [tb/test_timer_unit_clock_prescaler_select.sv]
// Self-checking testbench of the timer unit clock control block
`timescale 1ns/1ps
module test_timer_unit_clock_prescaler_select import tuc_pkg::*; ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  tuc_apb_req_s apb_req = '0;
  tuc_apb_rsp_s apb_rsp;
  logic [TUC_MAX_CH-1:0] timer_input_pin = '0;
  logic [1:0] unit_clock_on;
  logic [1:0] unit_rst_n;
  logic [TUC_MAX_CH-1:0][15:0] channel_mode;
  logic [TUC_MAX_CH-1:0] channel_op_clock;
  logic [TUC_MAX_CH-1:0] channel_count_clock;
  int n_errors = 0;
  int num_checks = 0;
  int seed = 6753;
  logic [31:0] rd;
  logic err;
  logic diff;
  always #2.5 pclk = ~pclk;
  tuc_clock_ctrl #(.NUM_CH0(TUC_MAX_CH0), .NUM_CH1(TUC_MAX_CH1)) tuc_clock_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .timer_input_pin(timer_input_pin), .unit_clock_on(unit_clock_on), .unit_rst_n(unit_rst_n),
    .channel_mode(channel_mode), .channel_op_clock(channel_op_clock),
    .channel_count_clock(channel_count_clock));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [21:0] ba(input logic [19:0] idx);
    return {idx, 2'b00};
  endfunction : ba
  function automatic logic [21:0] mode_addr(input int ch);
    if (ch < 8) return ba(20'(TUC_IDX_MODE0 + TUC_IDX_STEP * ch));
    return ba(20'(TUC_IDX_MODE1 + TUC_IDX_STEP * (ch - 8)));
  endfunction : mode_addr
  function automatic logic edge_hit(input int e, input logic old_v, input logic new_v);
    if (e == 0) return old_v & ~new_v;
    if (e == 1) return ~old_v & new_v;
    return old_v ^ new_v;
  endfunction : edge_hit
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [21:0] addr, input logic [31:0] wd, input logic [3:0] strb);
    int i;
    @(posedge pclk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= addr;
    apb_req.pwdata <= wd;
    apb_req.pstrb <= strb;
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    i = 0;
    @(posedge pclk);
    // Values read here are those that stood up to this edge
    while (apb_rsp.pready !== 1'b1 && i < 20) begin
      @(posedge pclk);
      i++;
    end
    if (i == 20) check("pready", 32'h1, 32'h0);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [21:0] addr, input logic [31:0] wd);
    apb(1'b1, addr, wd, 4'h3);
  endtask : wr
  task automatic rdchk(input string what, input logic [21:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0, 4'h0);
    check(what, exp, rd);
  endtask : rdchk
  // Cycles between two op clock pulses; diff flags count clock deviating
  task automatic period(input int ch, output logic [31:0] per);
    int i;
    i = 0;
    diff = 1'b0;
    @(negedge pclk);
    while (channel_op_clock[ch] !== 1'b1 && i < 200) begin
      @(negedge pclk);
      i++;
    end
    per = 1;
    @(negedge pclk);
    while (channel_op_clock[ch] !== 1'b1 && per < 200) begin
      diff |= channel_op_clock[ch] ^ channel_count_clock[ch];
      @(negedge pclk);
      per++;
    end
  endtask : period
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // ****************************************
  // Tests
  // ****************************************
  initial begin : watchdog
    #(5 * 20000);
    check("watchdog", 32'h0, 32'h1);
    report_and_stop;
  end
  initial begin : main
    logic [3:0] ka;
    logic [3:0] kb;
    logic [31:0] v;
    logic lvl;
    int cnt;
    int pulses;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("enable reset", ba(TUC_IDX_PCE), 32'h0);
    rdchk("prescaler1 reset", ba(TUC_IDX_PRESCALER_SELECT_UNIT1), 32'h0);
    check("clock gate off", 32'h0, {30'h0, unit_clock_on});
    check("unit reset held", 32'h0, {30'h0, unit_rst_n});
    wr(ba(TUC_IDX_PRESCALER_SELECT_UNIT0), 32'h21);
    rdchk("prescaler0 while off", ba(TUC_IDX_PRESCALER_SELECT_UNIT0), 32'h0);
    wr(mode_addr(8), 32'h8000);
    rdchk("mode while off", mode_addr(8), 32'h0);
    $display("test reset done");
    apb(1'b1, ba(TUC_IDX_PCE), 32'h3, 4'h1);
    rdchk("enable readback", ba(TUC_IDX_PCE), 32'h3);
    check("clock gate on", 32'h3, {30'h0, unit_clock_on});
    check("unit reset free", 32'h3, {30'h0, unit_rst_n});
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      wr(mode_addr(i < 4 ? i : i + 4), v);
      rdchk("mode readback", mode_addr(i < 4 ? i : i + 4), {16'h0, v[15:0] & TUC_MODE_MASK});
      check("mode output", {16'h0, v[15:0] & TUC_MODE_MASK}, {16'h0, channel_mode[i < 4 ? i : i + 4]});
    end
    v = $random(seed);
    apb(1'b1, ba(TUC_IDX_PRESCALER_SELECT_UNIT1), {24'h0, v[7:0]}, 4'h1);
    rdchk("prescaler readback", ba(TUC_IDX_PRESCALER_SELECT_UNIT1), {24'h0, v[7:0]});
    apb(1'b0, ba(TUC_IDX_PCE + 20'h1), 32'h0, 4'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    apb(1'b0, ba(TUC_IDX_PCE) | 22'h1, 32'h0, 4'h0);
    check("misaligned error", 32'h1, {31'h0, err});
    $display("test registers done");
    wr(mode_addr(0), 32'h0);
    wr(mode_addr(1), 32'h8000);
    wr(mode_addr(8), 32'h0);
    wr(mode_addr(9), 32'h8000);
    for (int j = 0; j < 4; j++) begin
      v = $random(seed);
      ka = (j == 0) ? 4'h0 : 4'(v[7:0] % 7);
      kb = (j == 0) ? 4'h6 : 4'(v[15:8] % 7);
      wr(ba(TUC_IDX_PRESCALER_SELECT_UNIT0), {24'h0, kb, ka});
      wr(ba(TUC_IDX_PRESCALER_SELECT_UNIT1), {24'h0, ka, kb});
      period(0, v);
      check("rate a unit0", 32'h1 << ka, v);
      check("count clock follows op", 32'h0, {31'h0, diff});
      period(1, v);
      check("rate b unit0", 32'h1 << kb, v);
      period(8, v);
      check("rate a unit1", 32'h1 << kb, v);
      period(9, v);
      check("rate b unit1", 32'h1 << ka, v);
    end
    $display("test prescaler done");
    wr(ba(TUC_IDX_PRESCALER_SELECT_UNIT0), 32'h0);
    for (int e = 0; e < 3; e++) begin
      wr(mode_addr(2), 32'h1000 | (e << 6));
      cnt = 0;
      pulses = 0;
      lvl = 1'b0;
      fork
        begin
          repeat (16) begin
            v = $random(seed);
            @(posedge pclk);
            timer_input_pin[2] <= v[0];
            cnt += int'(edge_hit(e, lvl, v[0]));
            lvl = v[0];
            repeat (2) @(posedge pclk);
          end
          timer_input_pin[2] <= 1'b0;
          cnt += int'(edge_hit(e, lvl, 1'b0));
        end
        repeat (64) begin
          @(negedge pclk);
          if (channel_count_clock[2] === 1'b1) pulses++;
        end
      join
      check("pin edge count", cnt, pulses);
    end
    $display("test count clock done");
    apb(1'b1, ba(TUC_IDX_PCE), 32'h2, 4'h1);
    // Gate flops change at the write edge; look once they have settled
    @(negedge pclk);
    check("gate unit0 off", 32'h2, {30'h0, unit_clock_on});
    check("unit0 reset", 32'h2, {30'h0, unit_rst_n});
    pulses = 0;
    repeat (10) begin
      @(negedge pclk);
      if (channel_op_clock[0] !== 1'b0) pulses++;
    end
    check("pulses while off", 32'h0, pulses);
    rdchk("mode read while off", mode_addr(1), 32'h0);
    rdchk("unit1 untouched", mode_addr(9), 32'h8000);
    apb(1'b1, ba(TUC_IDX_PCE), 32'h3, 4'h1);
    rdchk("mode cleared by reset", mode_addr(1), 32'h0);
    $display("test disable done");
    report_and_stop;
  end
endmodule : test_timer_unit_clock_prescaler_select
